// [dv/girq_chk.sv]
`timescale 1ns/1ps
// ====================
// Port checker
module girq_chk (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire vectorReq,
    input wire vectorAck,
    input wire pushPc,
    input wire stackFull,
    input wire sleepMode,
    input wire lowVoltageResetEn,
    input wire detectorOn,
    input wire bandgapOn
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_answer: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o) else $error("ack missing");
    a_req_hold: assert property (vectorReq && !vectorAck |=> vectorReq)
        else $error("request dropped early");
    a_push_after: assert property (vectorReq && vectorAck |=> pushPc && !vectorReq)
        else $error("no push after ack");
    a_push_single: assert property (pushPc |=> !pushPc)
        else $error("push too long");
    a_full_blocks: assert property ($rose(vectorReq) |-> !$past(stackFull))
        else $error("vector with full stack");
    a_sleep_off: assert property (sleepMode [*4] |-> !detectorOn)
        else $error("detector on in sleep");
    a_bandgap_lvr: assert property (lowVoltageResetEn [*4] |-> bandgapOn)
        else $error("bandgap off");
endmodule // girq_chk
bind girq_top girq_chk i_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .vectorReq(vectorReq), .vectorAck(vectorAck), .pushPc(pushPc), .stackFull(stackFull), .sleepMode(sleepMode),
    .lowVoltageResetEn(lowVoltageResetEn), .detectorOn(detectorOn), .bandgapOn(bandgapOn));

// [dv/girq_core_model.sv]
`timescale 1ns/1ps
// ====================
// Core sequencer and stack
module girq_core_model #(parameter int DEPTH = 1) (
    input wire clk,
    input wire rst,
    input wire vectorReq,
    input wire pushPc,
    input wire [1:0] retCmd,
    input wire [3:0] ackWait,
    output logic vectorAck,
    output wire stackFull,
    output logic isrExitReenable,
    output logic isrExitPlain
);
    int depth;
    int waitCnt;
    assign stackFull = depth >= DEPTH;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            depth <= 0;
            waitCnt <= 0;
            vectorAck <= 1'b0;
            isrExitReenable <= 1'b0;
            isrExitPlain <= 1'b0;
        end else begin
            // Push on entry, pop on exit
            if (pushPc)
                depth <= depth + 1;
            else if (retCmd != 2'b0 && depth > 0)
                depth <= depth - 1;
            isrExitReenable <= retCmd[1] && depth > 0;
            isrExitPlain <= retCmd[0] && depth > 0;
            // Slow answers stretch the request hold
            waitCnt <= (vectorReq && !vectorAck) ? waitCnt + 1 : 0;
            vectorAck <= vectorReq && !vectorAck && waitCnt >= ackWait;
        end
    end
endmodule // girq_core_model

// [dv/girq_tb.sv]
`timescale 1ns/1ps
module testbench;
    logic clk, rst, we, cyc, stb, nvm, tA, tP, low_voltage_reset, slp;
    logic [3:0] adr, sel, ackWait;
    logic [31:0] di, rv;
    logic [7:0] below;
    logic [1:0] retCmd;
    logic [15:0] lf;
    wire [31:0] dout;
    wire [2:0] thr;
    wire ack, vReq, vSel, push, wake, detOn, bgOn, vAck, full, exR, exP;
    int failures, checksDone, wakes, w, i;
    girq_top i_girq_top (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(di), .wb_dat_o(dout), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .nvmWriteDone(nvm), .timerMatchA(tA),
        .timerMatchP(tP), .belowThreshold(below), .lowVoltageResetEn(low_voltage_reset), .sleepMode(slp), .stackFull(full),
        .vectorAck(vAck), .isrExitReenable(exR), .isrExitPlain(exP), .vectorReq(vReq), .vectorSel(vSel),
        .pushPc(push), .wakeUp(wake), .detectorOn(detOn), .bandgapOn(bgOn), .thresholdSelect(thr));
    girq_core_model #(.DEPTH(1)) i_girq_core_model (.clk(clk), .rst(rst), .vectorReq(vReq), .pushPc(push),
        .retCmd(retCmd), .ackWait(ackWait), .vectorAck(vAck), .stackFull(full), .isrExitReenable(exR),
        .isrExitPlain(exP));
    // ====================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= wr;
        di <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rv = dout;
        if (n >= 50) failures++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(rv, e);
    endtask
    task automatic pulse(input logic [2:0] p);
        {nvm, tA, tP} <= p;
        @(posedge clk);
        {nvm, tA, tP} <= 3'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic leave(input logic [1:0] k);
        retCmd <= k;
        @(posedge clk);
        retCmd <= 2'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic waitPush(input logic s);
        int n;
        for (n = 0; n < 100 && push !== 1'b1; n++) begin
            @(negedge clk);
            if (vReq === 1'b1) chk(vSel, s);
        end
        if (n >= 100) failures++;
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
    initial begin
        #600000;
        failures++;
        wrap_up();
    end
    // ====================
    // Scenarios
    initial begin
        {rst, cyc, stb, we, nvm, tA, tP, low_voltage_reset, slp} = 9'h100;
        {adr, di, sel, below, retCmd, ackWait} = {4'h0, 32'h0, 4'hf, 8'h0, 2'h0, 4'h0};
        {failures, checksDone, wakes, lf} = {32'h0, 32'h0, 32'h0, 16'h0008};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 4; i++) rdc({i[1:0], 2'b0}, 32'h0);
        rdc(4'h6, 32'h0);
        for (i = 0; i < 4; i++) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            bus(4'h8, 1'b1, {16'h0, lf});
            rdc(4'h8, {28'h0, lf[3:0]});
        end
        bus(4'h0, 1'b1, 32'hff);
        rdc(4'h0, 32'h1f);
        chk({detOn, bgOn, thr}, 32'h1f);
        for (i = 0; i < 8; i++) begin
            bus(4'h0, 1'b1, 32'h10 | i);
            below <= 8'h1 << i;
            repeat (4) @(posedge clk); // settle wait
            rdc(4'h0, 32'h30 | i);
            below <= ~(8'h1 << i);
            repeat (4) @(posedge clk);
            rdc(4'h0, 32'h10 | i);
        end
        w = wakes;
        below <= 8'hff;
        repeat (400) @(posedge clk);
        below <= 8'h0;
        repeat (5) @(posedge clk);
        below <= 8'hff;
        repeat (700) @(posedge clk);
        rdc(4'h4, 32'h0);
        repeat (60) @(posedge clk);
        rdc(4'h4, 32'h2);
        chk(wakes, w + 1);
        bus(4'h4, 1'b1, 32'h8);
        repeat (2) @(posedge clk);
        w = wakes;
        pulse(3'b001);
        chk(wakes, w);
        bus(4'h4, 1'b1, 32'h0);
        pulse(3'b001);
        chk(wakes, w + 1);
        bus(4'h4, 1'b1, 32'h0);
        bus(4'h8, 1'b1, 32'h5);
        bus(4'hc, 1'b1, 32'h13);
        ackWait <= 4'h5;
        pulse(3'b110);
        waitPush(1'b0);
        ackWait <= 4'h0;
        rdc(4'hc, 32'h0b);
        rdc(4'h4, 32'h5);
        bus(4'hc, 1'b1, 32'h1b);
        repeat (10) @(posedge clk);
        chk(vReq, 32'h0);
        leave(2'b01);
        waitPush(1'b1);
        rdc(4'hc, 32'h03);
        leave(2'b10);
        rdc(4'hc, 32'h13);
        bus(4'h4, 1'b1, 32'h0);
        pulse(3'b010);
        waitPush(1'b1);
        leave(2'b01);
        rdc(4'hc, 32'h03);
        {slp, low_voltage_reset} <= 2'b11;
        repeat (8) @(posedge clk);
        chk({detOn, bgOn}, 32'h1);
        wrap_up();
    end
endmodule // testbench

// [pkg/girq_defs.vh]
`ifndef GIRQ_DEFS_VH
`define GIRQ_DEFS_VH

// Register word offsets (byte addresses)
`define GIRQ_ADDR_LOW_VOLTAGE_DETECT_CONTROL 4'h0
`define GIRQ_ADDR_SRCF 4'h4
`define GIRQ_ADDR_SRCE 4'h8
`define GIRQ_ADDR_GRP 4'hc
// Control register fields
`define GIRQ_LOW_VOLTAGE_DETECT_CONTROL_STAT 5
`define GIRQ_LOW_VOLTAGE_DETECT_CONTROL_EN 4
`define GIRQ_LOW_VOLTAGE_DETECT_CONTROL_BG 3
`define GIRQ_LOW_VOLTAGE_DETECT_CONTROL_RST 8'h00
// Source flag / enable bit positions
`define GIRQ_SRC_NVM 0
`define GIRQ_SRC_LV 1
`define GIRQ_SRC_TA 2
`define GIRQ_SRC_TP 3
// Group register: [1:0] vector enables, [3:2] vector flags, [4] global enable
`define GIRQ_GRP_EN0 0
`define GIRQ_GRP_FL0 2
`define GIRQ_GRP_GIE 4
// Flag assert delay in ns and cycles at 20 ns
`define GIRQ_LVD_DELAY_NS 15000
`define GIRQ_CLK_NS 20
`define GIRQ_LVD_DELAY_CYC (`GIRQ_LVD_DELAY_NS / `GIRQ_CLK_NS)
`define GIRQ_CNT_W 12

`endif

// [rtl/girq_lv_filter.v]
`timescale 1ns/1ps
`include "girq_defs.vh"
// ==========================================================
// Sustained-low delay filter
module girq_lv_filter (
    input wire clk,
    input wire rst,
    input wire statusIn,
    output reg pulseOut
);
    reg [`GIRQ_CNT_W-1:0] cnt_q;
    reg done_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {`GIRQ_CNT_W{1'b0}};
            done_q <= 1'b0;
            pulseOut <= 1'b0;
        end else begin
            pulseOut <= 1'b0;
            if (!statusIn) begin
                cnt_q <= {`GIRQ_CNT_W{1'b0}};
                done_q <= 1'b0;
            end else if (!done_q) begin
                if (cnt_q == `GIRQ_LVD_DELAY_CYC - 1) begin
                    done_q <= 1'b1;
                    pulseOut <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule // girq_lv_filter

// [rtl/girq_top.v]
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`include "girq_defs.vh"
// Notes on behaviour
// - Write-done sets memory write-done flag
// - Write-done vectors when all enables, stack
// - Entry clears global enable, group flag
// - Low voltage sets low-voltage request flag
// - Low-voltage vectors when enables, stack
// - Two timer match sources, own bits
// - Timer match vectors when enables, stack
// - Any source flag rising edge wakes device
// - Flags stay set until cleared
// - Vectoring pushes only program counter
// - Reenable return sets global enable
// - Status bit read-only, top zero
// - Enable bit switches detector
// - Bandgap on for detector, reset, bit
// - Threshold field selects comparison
// - Status follows below-threshold compare
// - Detector off during sleep
// - Request flag after fixed delay
// - Group flag set by member flags
module girq_top (
    input wire clk,
    input wire rst,
    input wire [3:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire nvmWriteDone,
    input wire timerMatchA,
    input wire timerMatchP,
    input wire [7:0] belowThreshold,
    input wire lowVoltageResetEn,
    input wire sleepMode,
    input wire stackFull,
    input wire vectorAck,
    input wire isrExitReenable,
    input wire isrExitPlain,
    output reg vectorReq,
    output reg vectorSel,
    output reg pushPc,
    output reg wakeUp,
    output reg detectorOn,
    output reg bandgapOn,
    output reg [2:0] thresholdSelect
);
    // ==========================================================
    // Pin synchronisers
    reg [7:0] belowS1_q, belowS2_q;
    reg sleepS1_q, sleepS2_q, lvrS1_q, lvrS2_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            belowS1_q <= 8'h00;
            belowS2_q <= 8'h00;
            sleepS1_q <= 1'b0;
            sleepS2_q <= 1'b0;
            lvrS1_q <= 1'b0;
            lvrS2_q <= 1'b0;
        end else begin
            belowS1_q <= belowThreshold;
            belowS2_q <= belowS1_q;
            sleepS1_q <= sleepMode;
            sleepS2_q <= sleepS1_q;
            lvrS1_q <= lowVoltageResetEn;
            lvrS2_q <= lvrS1_q;
        end
    end

    // ==========================================================
    // Registers
    reg [7:0] low_voltage_detect_control_q;
    reg [3:0] srcFlag_q, srcEn_q;
    reg [1:0] grpEn_q, grpFlag_q;
    reg gie_q, status_q, inService_q;
    wire lvPulse;
    wire busWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    wire busRd = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire detActive = low_voltage_detect_control_q[`GIRQ_LOW_VOLTAGE_DETECT_CONTROL_EN] && !sleepS2_q;
    wire belowSel = belowS2_q[low_voltage_detect_control_q[2:0]];
    wire [3:0] srcEvent;
    assign srcEvent[`GIRQ_SRC_NVM] = nvmWriteDone;
    assign srcEvent[`GIRQ_SRC_LV] = lvPulse;
    assign srcEvent[`GIRQ_SRC_TA] = timerMatchA;
    assign srcEvent[`GIRQ_SRC_TP] = timerMatchP;
    // Group 0: write-done and low voltage; group 1: timer
    wire [1:0] grpPend;
    assign grpPend[0] = |(srcFlag_q[1:0] & srcEn_q[1:0]);
    assign grpPend[1] = |(srcFlag_q[3:2] & srcEn_q[3:2]);
    wire [1:0] grpReady = grpFlag_q & grpEn_q & grpPend;
    wire canVector = gie_q && !stackFull && !inService_q && |grpReady;

    girq_lv_filter uFilter (
        .clk(clk),
        .rst(rst),
        .statusIn(status_q),
        .pulseOut(lvPulse)
    );

    // ==========================================================
    // Detector control and status
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            low_voltage_detect_control_q <= `GIRQ_LOW_VOLTAGE_DETECT_CONTROL_RST;
            status_q <= 1'b0;
            detectorOn <= 1'b0;
            bandgapOn <= 1'b0;
            thresholdSelect <= 3'h0;
        end else begin
            if (busWr && wb_adr_i == `GIRQ_ADDR_LOW_VOLTAGE_DETECT_CONTROL)
                low_voltage_detect_control_q <= {4'h0, wb_dat_i[3:0]} | {3'h0, wb_dat_i[4], 4'h0};
            status_q <= detActive && belowSel;
            detectorOn <= detActive;
            bandgapOn <= low_voltage_detect_control_q[`GIRQ_LOW_VOLTAGE_DETECT_CONTROL_EN] || lvrS2_q || low_voltage_detect_control_q[`GIRQ_LOW_VOLTAGE_DETECT_CONTROL_BG];
            thresholdSelect <= low_voltage_detect_control_q[2:0];
        end
    end

    // ==========================================================
    // Flags, enables, vectoring
    integer i;
    reg [3:0] srcFlag_d;
    reg [1:0] grpFlag_d;
    always @* begin
        srcFlag_d = srcFlag_q;
        if (busWr && wb_adr_i == `GIRQ_ADDR_SRCF)
            srcFlag_d = wb_dat_i[3:0];
        for (i = 0; i < 4; i = i + 1)
            if (srcEvent[i])
                srcFlag_d[i] = 1'b1;
        grpFlag_d = grpFlag_q;
        if (busWr && wb_adr_i == `GIRQ_ADDR_GRP)
            grpFlag_d = wb_dat_i[3:2];
        if (vectorReq && vectorAck)
            grpFlag_d[vectorSel] = 1'b0;
        if (|(srcFlag_d[1:0] & ~srcFlag_q[1:0]))
            grpFlag_d[0] = 1'b1;
        if (|(srcFlag_d[3:2] & ~srcFlag_q[3:2]))
            grpFlag_d[1] = 1'b1;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            srcFlag_q <= 4'h0;
            srcEn_q <= 4'h0;
            grpEn_q <= 2'h0;
            grpFlag_q <= 2'h0;
            gie_q <= 1'b0;
            inService_q <= 1'b0;
            vectorReq <= 1'b0;
            vectorSel <= 1'b0;
            pushPc <= 1'b0;
            wakeUp <= 1'b0;
        end else begin
            srcFlag_q <= srcFlag_d;
            grpFlag_q <= grpFlag_d;
            if (busWr && wb_adr_i == `GIRQ_ADDR_SRCE)
                srcEn_q <= wb_dat_i[3:0];
            if (busWr && wb_adr_i == `GIRQ_ADDR_GRP)
                grpEn_q <= wb_dat_i[1:0];
            wakeUp <= |(srcFlag_d & ~srcFlag_q);
            pushPc <= 1'b0;
            if (vectorReq && vectorAck) begin
                gie_q <= 1'b0;
                vectorReq <= 1'b0;
                pushPc <= 1'b1;
                inService_q <= 1'b0;
            end else if (canVector && !vectorReq) begin
                vectorReq <= 1'b1;
                inService_q <= 1'b1;
                vectorSel <= grpReady[0] ? 1'b0 : 1'b1;
            end else if (isrExitReenable) begin
                gie_q <= 1'b1;
            end else if (isrExitPlain) begin
                gie_q <= gie_q;
            end else if (busWr && wb_adr_i == `GIRQ_ADDR_GRP) begin
                gie_q <= wb_dat_i[`GIRQ_GRP_GIE];
            end
        end
    end

    // ==========================================================
    // Wishbone slave, registered answer one cycle after strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= busRd;
            if (busRd) begin
                case (wb_adr_i)
                    `GIRQ_ADDR_LOW_VOLTAGE_DETECT_CONTROL: wb_dat_o <= {26'h0, status_q, low_voltage_detect_control_q[4:0]};
                    `GIRQ_ADDR_SRCF: wb_dat_o <= {28'h0, srcFlag_q};
                    `GIRQ_ADDR_SRCE: wb_dat_o <= {28'h0, srcEn_q};
                    `GIRQ_ADDR_GRP: wb_dat_o <= {27'h0, gie_q, grpFlag_q, grpEn_q};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule // girq_top
